/* File: hdl/lre_pkg.sv */
// Constants and types shared by the literal and return execution block.
`default_nettype none
package lre_pkg;

   // ----------------------------------------------------------------
   // Instruction word layout
   // ----------------------------------------------------------------
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int LIT_LSB = 0;
   localparam int GRP_LSB = 10;
   localparam int GRP_W = 4;

   // ----------------------------------------------------------------
   // Opcode encodings
   // ----------------------------------------------------------------
   localparam logic [3:0] GRP_LOAD_LIT = 4'hc;
   localparam logic [3:0] GRP_RET_LIT = 4'hd;
   localparam logic [13:0] OP_RET_INTR = 14'h0009;
   localparam logic [13:0] OP_RET_SUB = 14'h0008;
   localparam logic [13:0] NOP_MASK = 14'h3f9f;
   localparam logic [13:0] NOP_VALUE = 14'h0000;

   // ----------------------------------------------------------------
   // Reset values, bit positions and cycle counts
   // ----------------------------------------------------------------
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam int PC_RESET = 0;
   localparam logic GIE_RESET = 1'b0;
   localparam int GIE_BIT = 7;
   localparam int RET_CYCLES = 2;
   localparam int SHORT_CYCLES = 1;

   // ----------------------------------------------------------------
   // Decoded operations and sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      LRE_OP_OTHER = 3'h0,
      LRE_OP_LOAD_LIT = 3'h1,
      LRE_OP_NOP = 3'h2,
      LRE_OP_RET_INTR = 3'h3,
      LRE_OP_RET_LIT = 3'h4,
      LRE_OP_RET_SUB = 3'h5
   } lre_op_t;

   typedef enum logic [0:0] {
      LRE_ST_EXEC = 1'b0,
      LRE_ST_FLUSH = 1'b1
   } lre_state_t;

endpackage
`default_nettype wire

/* File: hdl/lre_dec_if.sv */
// Carrier between the instruction decoder and the execution core.
`default_nettype none
interface lre_dec_if;
   logic [lre_pkg::INSTR_W-1:0] word;
   lre_pkg::lre_op_t op;
   logic [lre_pkg::DATA_W-1:0] literal;

   modport dec (input word, output op, output literal);
   modport core (output word, input op, input literal);
endinterface
`default_nettype wire

/* File: hdl/lre_decode.sv */
// Decoder that classifies one instruction word for the execution core.
`default_nettype none
module lre_decode (
   // Decode carrier
   lre_dec_if.dec dif
);

   // ----------------------------------------------------------------
   // Classification
   // ----------------------------------------------------------------
   logic [lre_pkg::GRP_W-1:0] grp;

   assign grp = dif.word[lre_pkg::GRP_LSB +: lre_pkg::GRP_W];
   assign dif.literal = dif.word[lre_pkg::LIT_LSB +: lre_pkg::DATA_W];

   always_comb begin
      if (grp == lre_pkg::GRP_LOAD_LIT) begin
         dif.op = lre_pkg::LRE_OP_LOAD_LIT;
      end else if (grp == lre_pkg::GRP_RET_LIT) begin
         dif.op = lre_pkg::LRE_OP_RET_LIT;
      end else if (dif.word == lre_pkg::OP_RET_INTR) begin
         dif.op = lre_pkg::LRE_OP_RET_INTR;
      end else if (dif.word == lre_pkg::OP_RET_SUB) begin
         dif.op = lre_pkg::LRE_OP_RET_SUB;
      end else if ((dif.word & lre_pkg::NOP_MASK) == lre_pkg::NOP_VALUE) begin
         dif.op = lre_pkg::LRE_OP_NOP;
      end else begin
         dif.op = lre_pkg::LRE_OP_OTHER;
      end
   end

endmodule
`default_nettype wire

/* File: hdl/lre_core.sv */
// Execution core for literal load, no-operation and the three returns.
`default_nettype none

// What this block does
// - Load literal into accumulator, one cycle, flags kept.
// - Interrupt return pops stack into counter, two cycles.
// - Interrupt return sets global interrupt enable bit.
// - Literal return writes literal into accumulator, flags kept.
// - Literal return reloads counter from stack, two cycles.
// - Subroutine return pops stack, accumulator untouched, two cycles.
module lre_core #(
   parameter int PC_W = 13
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Instruction fetch
   input wire logic instr_valid,
   input wire logic [lre_pkg::INSTR_W-1:0] instr_word,
   output logic instr_ready,
   // Call stack
   input wire logic [PC_W-1:0] stack_top_entry,
   output logic stack_pop,
   // Interrupt control
   input wire logic gie_clear,
   output logic global_interrupt_enable,
   output logic [7:0] interrupt_control_register,
   // Core state
   output logic [lre_pkg::DATA_W-1:0] accumulator,
   output logic [PC_W-1:0] program_counter,
   output logic status_write,
   output logic unsupported
);

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   if (PC_W < 1 || PC_W > 16) begin : g_bad_pc_w
      $error("PC_W must lie between 1 and 16.");
   end

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   lre_dec_if dif ();

   assign dif.word = instr_word;

   lre_decode u_decode (
      .dif(dif)
   );

   // ----------------------------------------------------------------
   // Sequencer and architectural state
   // ----------------------------------------------------------------
   lre_pkg::lre_state_t state_ff;
   lre_pkg::lre_state_t nxt_state;
   logic [lre_pkg::DATA_W-1:0] acc_ff;
   logic [lre_pkg::DATA_W-1:0] nxt_acc;
   logic [PC_W-1:0] pc_ff;
   logic [PC_W-1:0] nxt_pc;
   logic gie_ff;
   logic nxt_gie;
   logic pop_ff;
   logic nxt_pop;
   logic unsup_ff;
   logic nxt_unsup;
   logic take;
   logic is_ret;

   // The second cycle of a return refuses the word offered meanwhile.
   assign instr_ready = (state_ff == lre_pkg::LRE_ST_EXEC);
   assign take = instr_valid && instr_ready;
   // The three returns share the pop, the counter load and the flush.
   assign is_ret = (dif.op == lre_pkg::LRE_OP_RET_INTR) ||
      (dif.op == lre_pkg::LRE_OP_RET_LIT) ||
      (dif.op == lre_pkg::LRE_OP_RET_SUB);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // A return spends one more cycle in which the fetched word is refused.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         lre_pkg::LRE_ST_EXEC: begin
            if (take && is_ret) begin
               nxt_state = lre_pkg::LRE_ST_FLUSH;
            end
         end
         lre_pkg::LRE_ST_FLUSH: begin
            nxt_state = lre_pkg::LRE_ST_EXEC;
         end
         default: begin
            nxt_state = lre_pkg::LRE_ST_EXEC;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= lre_pkg::LRE_ST_EXEC;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // Accumulator
   // ----------------------------------------------------------------
   // Only the two literal forms write it; every other word, the returns
   // without a literal included, leaves it as it was.
   always_comb begin
      nxt_acc = acc_ff;
      if (take) begin
         case (dif.op)
            lre_pkg::LRE_OP_LOAD_LIT: begin
               nxt_acc = dif.literal;
            end
            lre_pkg::LRE_OP_RET_LIT: begin
               nxt_acc = dif.literal;
            end
            default: begin
               nxt_acc = acc_ff;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_ff <= lre_pkg::ACC_RESET;
      end else begin
         acc_ff <= nxt_acc;
      end
   end

   // ----------------------------------------------------------------
   // Program counter
   // ----------------------------------------------------------------
   // A return takes the popped entry; any other accepted word, an unknown
   // one included, steps the counter by one.
   always_comb begin
      nxt_pc = pc_ff;
      if (take) begin
         if (is_ret) begin
            nxt_pc = stack_top_entry;
         end else begin
            nxt_pc = pc_ff + PC_W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_ff <= PC_W'(lre_pkg::PC_RESET);
      end else begin
         pc_ff <= nxt_pc;
      end
   end

   // ----------------------------------------------------------------
   // Global interrupt enable
   // ----------------------------------------------------------------
   // A clear drops the bit at the next edge, but an interrupt return taken
   // in the same cycle sets it and wins.
   always_comb begin
      nxt_gie = gie_ff;
      if (gie_clear) begin
         nxt_gie = 1'b0;
      end
      if (take && (dif.op == lre_pkg::LRE_OP_RET_INTR)) begin
         nxt_gie = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gie_ff <= lre_pkg::GIE_RESET;
      end else begin
         gie_ff <= nxt_gie;
      end
   end

   // ----------------------------------------------------------------
   // One-cycle pulses
   // ----------------------------------------------------------------
   // The pop request and the unknown-word flag stand for one cycle only;
   // the stack and the fetch path must act on them at once.
   always_comb begin
      nxt_pop = take && is_ret;
      nxt_unsup = take && (dif.op == lre_pkg::LRE_OP_OTHER);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pop_ff <= 1'b0;
         unsup_ff <= 1'b0;
      end else begin
         pop_ff <= nxt_pop;
         unsup_ff <= nxt_unsup;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign accumulator = acc_ff;
   assign program_counter = pc_ff;
   assign global_interrupt_enable = gie_ff;
   assign stack_pop = pop_ff;
   assign unsupported = unsup_ff;
   // None of these instructions touches a status flag.
   assign status_write = 1'b0;

   always_comb begin
      interrupt_control_register = 8'h00;
      interrupt_control_register[lre_pkg::GIE_BIT] = gie_ff;
   end

endmodule
`default_nettype wire

/* File: bench/lre_checker.sv */
// Assertions on the ports of the execution core.
`default_nettype none
module lre_checker #(
   parameter int PC_W = 13
) (
   // Clock and fetch
   input wire logic clk,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire logic [13:0] instr_word,
   input wire logic instr_ready,
   // Stack and interrupts
   input wire logic [PC_W-1:0] stack_top_entry,
   input wire logic stack_pop,
   input wire logic global_interrupt_enable,
   input wire logic [7:0] interrupt_control_register,
   // Core state
   input wire logic [7:0] accumulator,
   input wire logic [PC_W-1:0] program_counter,
   input wire logic status_write
);
   wire tk = instr_valid && instr_ready;
   wire [3:0] grp = instr_word[13:10];
   wire ri = tk && instr_word == lre_pkg::OP_RET_INTR;
   wire rl = tk && grp == lre_pkg::GRP_RET_LIT;
   wire no_operation = (instr_word & lre_pkg::NOP_MASK) == lre_pkg::NOP_VALUE;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   chk_load_lit: assert property (tk && grp == lre_pkg::GRP_LOAD_LIT
      |=> accumulator == $past(instr_word[7:0]) && instr_ready)
      else $error("load wrong");
   chk_nop_step: assert property (tk && no_operation |=> !stack_pop &&
      program_counter == $past(program_counter) + 1'h1 && $stable(accumulator))
      else $error("no-op wrong");
   chk_intr_ret: assert property (ri |=> stack_pop && !instr_ready
      && program_counter == $past(stack_top_entry) ##1 instr_ready)
      else $error("interrupt return wrong");
   chk_enable_set: assert property (ri |=> global_interrupt_enable
      && interrupt_control_register == 8'h80)
      else $error("enable not set");
   chk_ret_acc: assert property (rl |=>
      accumulator == $past(instr_word[7:0]))
      else $error("literal return data wrong");
   chk_ret_pc: assert property (rl |=> stack_pop &&
      program_counter == $past(stack_top_entry) ##1 !stack_pop && instr_ready)
      else $error("literal return pc wrong");
   chk_sub_ret: assert property (tk && instr_word == lre_pkg::OP_RET_SUB
      |=> program_counter == $past(stack_top_entry) && $stable(accumulator))
      else $error("subroutine return wrong");
   chk_flags_kept: assert property (status_write == 1'h0)
      else $error("flags written");
endmodule
bind lre_core lre_checker #(.PC_W(PC_W)) u_chk (.*);
`default_nettype wire

/* File: bench/lre_core_bench.sv */
// Self-checking bench for the literal and return execution core.
`default_nettype none
module lre_core_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0, rst_n = 1'h0, instr_valid = 1'h0, gie_clear = 1'h0;
   logic [13:0] instr_word = '0;
   logic [12:0] stack_top_entry = '0, program_counter, e_pc = '0;
   logic [7:0] accumulator, interrupt_control_register, e_acc = '0;
   logic instr_ready, stack_pop, global_interrupt_enable, e_gie = 1'h0;
   logic status_write, unsupported, seen = 1'h0;
   logic [23:0] q[$];
   wire [23:0] obs = {accumulator, program_counter, global_interrupt_enable,
      stack_pop, unsupported};
   int error_cnt = 0, num_checks = 0;
   lre_core dut (.*);
   always #50 clk = ~clk;
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Result of each taken word shows one edge later.
   always @(posedge clk) begin
      if (seen) chk(obs, q.pop_front());
      seen = rst_n && instr_valid && instr_ready;
   end
   // Valid stays up between words, so a flush cycle also sees a refusal.
   task automatic op(input logic [13:0] w, input logic c);
      int n;
      logic lit, ret, unsup;
      n = 0;
      // Both literal groups write the accumulator.
      lit = (w[13:11] == lre_pkg::GRP_LOAD_LIT[3:1]);
      ret = (w == lre_pkg::OP_RET_INTR || w == lre_pkg::OP_RET_SUB ||
         w[13:10] == lre_pkg::GRP_RET_LIT);
      unsup = !(lit || ret || (w & lre_pkg::NOP_MASK) == lre_pkg::NOP_VALUE);
      while (instr_ready !== 1'h1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 4) begin
         error_cnt++;
         summarize();
      end
      instr_valid = 1'h1;
      instr_word = w;
      stack_top_entry = 13'($urandom);
      gie_clear = c;
      if (lit) e_acc = w[7:0];
      if (ret)
         e_pc = stack_top_entry;
      else
         e_pc = e_pc + 13'h1;
      if (w == lre_pkg::OP_RET_INTR) e_gie = 1'h1;
      else if (c) e_gie = 1'h0;
      q.push_back({e_acc, e_pc, e_gie, ret, unsup});
      @(posedge clk);
      #1;
      // A clear given with a return must not linger into its refused cycle.
      if (instr_ready !== 1'h1) gie_clear = 1'h0;
   endtask
   initial begin
      void'($urandom(32'hc0a5));
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'h1;
      op(14'h3000, 1'h0);
      op(14'h30ff, 1'h0);
      op({6'h30, 8'($urandom)}, 1'h0);
      $display("test literal loads done");
      op(14'h0009, 1'h0);
      op({6'h34, 8'($urandom)}, 1'h0);
      op(14'h0008, 1'h0);
      op(14'h0009, 1'h0);
      op(14'h3055, 1'h0);
      $display("test returns done");
      for (int i = 0; i < 4; i++) op(14'(i * 32), 1'(i == 1));
      op(14'h0008, 1'h0);
      $display("test no-ops done");
      op(14'h2000, 1'h0);
      op(14'h0009, 1'h1);
      op({6'h20, 8'($urandom)}, 1'h0);
      $display("test other words done");
      instr_valid = 1'h0;
      repeat (3) @(posedge clk);
      #1;
      chk(24'(q.size()), 24'h0);
      summarize();
   end
endmodule
`default_nettype wire
